//--- rtl/ecc_pkg.sv
package ecc_pkg;

   // -----------------------------------------------------------------
   // widths and command layout
   // -----------------------------------------------------------------
   localparam int CMD_W        = 8;
   localparam int DATA_W       = 24;
   localparam int SEL_W        = 5;
   localparam int CMD_LSB      = DATA_W - CMD_W;  // command sits at top of shift reg
   localparam int CMD_EXIT_BIT = 5;               // leave_halt_bit
   localparam int CMD_GO_BIT   = 6;
   localparam int CMD_DIR_BIT  = 7;               // 1 = read, 0 = write
   localparam int SYNC_W       = 6;

   // -----------------------------------------------------------------
   // target select codes
   // -----------------------------------------------------------------
   localparam logic [4:0] SEL_STATUS = 5'h00;
   localparam logic [4:0] SEL_BPCNT  = 5'h01;
   localparam logic [4:0] SEL_BPCTRL = 5'h02;
   localparam logic [4:0] SEL_LIM0   = 5'h05;
   localparam logic [4:0] SEL_LIM1   = 5'h06;
   localparam logic [4:0] SEL_GDB    = 5'h09;
   localparam logic [4:0] SEL_PDB    = 5'h0A;
   localparam logic [4:0] SEL_HELD   = 5'h0B;
   localparam logic [4:0] SEL_GOTO   = 5'h0C;
   localparam logic [4:0] SEL_TRCNT  = 5'h0D;
   localparam logic [4:0] SEL_FETCH  = 5'h0F;
   localparam logic [4:0] SEL_DECODE = 5'h10;
   localparam logic [4:0] SEL_EXEC   = 5'h11;
   localparam logic [4:0] SEL_TRACE  = 5'h12;
   localparam logic [4:0] SEL_NONE   = 5'h1F;

   // -----------------------------------------------------------------
   // status/control fields and codes
   // -----------------------------------------------------------------
   localparam int ST_TRACE_EN_BIT = 0;
   localparam int ST_IRQ_MODE_BIT = 1;
   localparam logic [23:0] STATUS_RESET = 24'h000000;
   localparam logic [1:0]  CORE_RUN     = 2'h0;
   localparam logic [1:0]  CORE_WAIT    = 2'h1;
   localparam logic [1:0]  CORE_BUS     = 2'h2;
   localparam logic [1:0]  CORE_DEBUG   = 2'h3;
   localparam logic [2:0]  HOLDOFF_CYCLES = 3'h4;  // ignore the line after release

   // -----------------------------------------------------------------
   // state types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ECC_L_CMD  = 3'b001,
      ECC_L_LOAD = 3'b010,
      ECC_L_DATA = 3'b100
   } ecc_link_t;

   typedef enum logic [3:0] {
      ECC_D_RUN  = 4'b0001,
      ECC_D_HALT = 4'b0010,
      ECC_D_DBG  = 4'b0100,
      ECC_D_STEP = 4'b1000
   } ecc_dbg_t;

   // 24-bit targets; all others are 16 bits wide
   function automatic logic ecc_is_wide(input logic [4:0] sel);
      ecc_is_wide = (sel == SEL_STATUS) || (sel == SEL_GDB) || (sel == SEL_PDB) ||
                    (sel == SEL_HELD) || (sel == SEL_GOTO);
   endfunction : ecc_is_wide

   function automatic logic ecc_can_write(input logic [4:0] sel);
      ecc_can_write = (sel == SEL_STATUS) || (sel == SEL_BPCNT) || (sel == SEL_BPCTRL) ||
                      (sel == SEL_LIM0) || (sel == SEL_LIM1) || (sel == SEL_PDB) ||
                      (sel == SEL_GOTO) || (sel == SEL_TRCNT);
   endfunction : ecc_can_write

endpackage : ecc_pkg

//--- rtl/ecc_rf_if.sv
`timescale 1ns/1ps
// register bank port between command front end and storage
interface ecc_rf_if #(
   parameter int AW = 5,
   parameter int DW = 24
);
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface : ecc_rf_if

//--- rtl/ecc_regmem.sv
`timescale 1ns/1ps
module ecc_regmem import ecc_pkg::*; #(
   parameter int AW = 5,
   parameter int DW = 24
) (
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   input  wire logic clk_en_in,
   ecc_rf_if.mem     rf
);
   localparam int DEPTH = 1 << AW;

   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] mem_d [DEPTH];
   logic [DW-1:0] rdata_q;

   // -----------------------------------------------------------------
   // one storage word per target code, cleared on reset
   // -----------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_comb begin
         mem_d[i] = (rf.we && (rf.addr == AW'(i))) ? rf.wdata : mem_q[i];
      end
      always_ff @(posedge clock_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mem_q[i] <= '0;
         end else if (clk_en_in) begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   // registered read port
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= '0;
      end else if (clk_en_in) begin
         rdata_q <= mem_q[rf.addr];
      end
   end

   assign rf.rdata = rdata_q;

endmodule : ecc_regmem

//--- rtl/ecc_controller.sv
`timescale 1ns/1ps
// How it works
// - emulation access only after unlock instruction; stays usable in normal run (here only status/control, other targets need debug)
// - no own pins: commands and data shift over TDI/TDO on TCK
// - halt line pulled low: core finishes instruction, saves pipeline, enters debug
// - on entering debug the device drives halt line low as acknowledge
// - halt line is wired-AND between processors, any holder halts all
// - command register is 8-bit serial shift register feeding interpreter
// - command bits 0 to 4 select target register
// - target codes 00 to 0D map to status, breakpoint, limit, bus registers
// - codes 0F to 11 address captures, 12 trace read, 1F none
// - bit 5 leaves debug only with go on a qualifying operation
// - bit 6 runs held instruction, then back to debug unless bit 5
// - go honoured only on program bus data write or no-register access
// - bit 7 gives direction: 0 write data in, 1 read out
// - interpreter uses command, update indication and halted flag for strobes
// - 24-bit status/control clears on reset, control RW, status read-only
// - core state field: 00 run, 01 wait/stop, 10 bus wait, 11 debug
module ecc_controller import ecc_pkg::*; #(
   parameter int AW = SEL_W
) (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        clk_en_in,
   input  wire logic        tck_in,
   input  wire logic        tdi_in,
   input  wire logic        shift_dr_in,
   input  wire logic        update_dr_in,
   input  wire logic        unlock_in,
   input  wire logic        halt_line_in,
   output logic             halt_line_out,
   output logic             halt_line_oe_out,
   output logic             tdo_out,
   input  wire logic        core_halted_in,
   input  wire logic        core_wait_in,
   input  wire logic        core_bus_wait_in,
   input  wire logic [2:0]  debug_cause_in,
   input  wire logic [23:0] gdb_capture_in,
   input  wire logic [23:0] held_instr_in,
   input  wire logic [15:0] fetch_addr_in,
   input  wire logic [15:0] decode_addr_in,
   input  wire logic [15:0] exec_addr_in,
   input  wire logic [15:0] trace_data_in,
   output logic             debug_req_out,
   output logic             core_go_out,
   output logic             core_exit_out,
   output logic             trace_enable_out,
   output logic             irq_mode_out,
   output logic             trace_advance_out
);

   // -----------------------------------------------------------------
   // reset release and pin synchronisers
   // -----------------------------------------------------------------
   logic              rst_s1_q;
   logic              rst_n;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic              tck_d_q;
   logic              upd_d_q;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else if (clk_en_in) begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // two stages on every pin; edge flops read only the second stage
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 6'h20;                  // halt line idles high, unlock low
         sync2_q <= 6'h20;
         tck_d_q <= 1'b0;
         upd_d_q <= 1'b0;
      end else if (clk_en_in) begin
         sync1_q <= {halt_line_in, unlock_in, update_dr_in, shift_dr_in, tdi_in, tck_in};
         sync2_q <= sync1_q;
         tck_d_q <= sync2_q[0];
         upd_d_q <= sync2_q[3];
      end
   end

   logic tck_s, tdi_s, shf_s, upd_s, unl_s, hl_s;
   logic tck_rise, tck_fall, upd_evt;

   assign tck_s    = sync2_q[0];
   assign tdi_s    = sync2_q[1];
   assign shf_s    = sync2_q[2];
   assign upd_s    = sync2_q[3];
   assign unl_s    = sync2_q[4];
   assign hl_s     = sync2_q[5];
   assign tck_rise = tck_s & ~tck_d_q;
   assign tck_fall = ~tck_s & tck_d_q;
   assign upd_evt  = upd_s & ~upd_d_q;

   // -----------------------------------------------------------------
   // register bank instance
   // -----------------------------------------------------------------
   ecc_rf_if #(.AW(AW), .DW(DATA_W)) rf ();

   ecc_regmem #(.AW(AW), .DW(DATA_W)) u_mem (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n),
      .clk_en_in (clk_en_in),
      .rf        (rf)
   );

   // -----------------------------------------------------------------
   // state declarations
   // -----------------------------------------------------------------
   ecc_link_t         link_q, link_d;
   logic [DATA_W-1:0] sh_q, sh_d;
   logic [CMD_W-1:0]  cmd_q, cmd_d;
   logic              tdo_q, tdo_d;
   logic              go_req_q, go_req_d;
   logic              go_ex_q, go_ex_d;
   logic              trc_q, trc_d;
   logic [1:0]        ctrl_q, ctrl_d;
   ecc_dbg_t          dbg_q, dbg_d;
   logic              req_q, req_d;
   logic              oe_q, oe_d;
   logic              go_q, go_d;
   logic              ex_q, ex_d;
   logic [2:0]        cause_q, cause_d;
   logic [2:0]        hold_q, hold_d;
   logic              ran_q, ran_d;
   logic              hlo_q;

   logic              halted;
   logic [1:0]        core_st;
   logic [DATA_W-1:0] stat_val;
   logic [DATA_W-1:0] rd_val;
   logic [4:0]        sel;
   logic [4:0]        new_sel;
   logic              acc_ok;

   assign halted  = (dbg_q == ECC_D_DBG);
   assign sel     = cmd_q[SEL_W-1:0];
   assign new_sel = sh_q[CMD_LSB +: SEL_W];
   assign acc_ok  = halted || (sel == SEL_STATUS);

   // core state field and status word, reserved bits zero
   always_comb begin
      if (halted) begin
         core_st = CORE_DEBUG;
      end else if (core_bus_wait_in) begin
         core_st = CORE_BUS;
      end else if (core_wait_in) begin
         core_st = CORE_WAIT;
      end else begin
         core_st = CORE_RUN;
      end
      stat_val = {16'h0000, core_st, 1'b0, cause_q, ctrl_q};
   end

   // read source decode
   always_comb begin
      if (!acc_ok) begin
         rd_val = '0;
      end else if (sel == SEL_STATUS) begin
         rd_val = stat_val;
      end else if (sel == SEL_GDB) begin
         rd_val = gdb_capture_in;
      end else if (sel == SEL_HELD) begin
         rd_val = held_instr_in;
      end else if (sel == SEL_FETCH) begin
         rd_val = {8'h00, fetch_addr_in};
      end else if (sel == SEL_DECODE) begin
         rd_val = {8'h00, decode_addr_in};
      end else if (sel == SEL_EXEC) begin
         rd_val = {8'h00, exec_addr_in};
      end else if (sel == SEL_TRACE) begin
         rd_val = {8'h00, trace_data_in};
      end else if (ecc_can_write(sel) && (sel != SEL_GOTO)) begin
         rd_val = rf.rdata;
      end else begin
         rd_val = '0;                                           // reserved, none, write-only
      end
   end

   // -----------------------------------------------------------------
   // serial link and command interpreter
   // -----------------------------------------------------------------
   always_comb begin
      link_d   = link_q;
      sh_d     = sh_q;
      cmd_d    = cmd_q;
      tdo_d    = tdo_q;
      go_req_d = 1'b0;
      go_ex_d  = 1'b0;
      trc_d    = 1'b0;
      ctrl_d   = ctrl_q;
      rf.we    = 1'b0;
      rf.addr  = sel;
      rf.wdata = ecc_is_wide(sel) ? sh_q : {8'h00, sh_q[DATA_W-1:8]};
      if (tck_fall) begin
         tdo_d = sh_q[0];
      end
      if (!unl_s) begin
         link_d = ECC_L_CMD;
      end else begin
         case (link_q)
            ECC_L_CMD: begin
               if (tck_rise && shf_s) begin
                  sh_d = {tdi_s, sh_q[DATA_W-1:1]};
               end
               if (upd_evt) begin
                  cmd_d   = sh_q[CMD_LSB +: CMD_W];
                  rf.addr = new_sel;                            // prime registered read
                  if (new_sel == SEL_NONE) begin
                     go_req_d = sh_q[CMD_LSB + CMD_GO_BIT];
                     go_ex_d  = sh_q[CMD_LSB + CMD_EXIT_BIT];
                  end else if (sh_q[CMD_LSB + CMD_DIR_BIT]) begin
                     link_d = ECC_L_LOAD;
                  end else begin
                     link_d = ECC_L_DATA;
                  end
               end
            end
            ECC_L_LOAD: begin
               sh_d   = rd_val;
               trc_d  = (sel == SEL_TRACE) && halted;
               link_d = ECC_L_DATA;
            end
            ECC_L_DATA: begin
               if (tck_rise && shf_s) begin
                  sh_d = {tdi_s, sh_q[DATA_W-1:1]};
               end
               if (upd_evt) begin
                  link_d = ECC_L_CMD;
                  if (!cmd_q[CMD_DIR_BIT] && acc_ok && ecc_can_write(sel)) begin
                     if (sel == SEL_STATUS) begin
                        ctrl_d = sh_q[ST_TRACE_EN_BIT +: 2];
                     end else begin
                        rf.we = 1'b1;
                     end
                     if (sel == SEL_PDB) begin
                        go_req_d = cmd_q[CMD_GO_BIT];
                        go_ex_d  = cmd_q[CMD_EXIT_BIT];
                     end
                  end
               end
            end
            default: link_d = ECC_L_CMD;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         link_q   <= ECC_L_CMD;
         sh_q     <= '0;
         cmd_q    <= '0;
         tdo_q    <= 1'b0;
         go_req_q <= 1'b0;
         go_ex_q  <= 1'b0;
         trc_q    <= 1'b0;
         ctrl_q   <= STATUS_RESET[1:0];
      end else if (clk_en_in) begin
         link_q   <= link_d;
         sh_q     <= sh_d;
         cmd_q    <= cmd_d;
         tdo_q    <= tdo_d;
         go_req_q <= go_req_d;
         go_ex_q  <= go_ex_d;
         trc_q    <= trc_d;
         ctrl_q   <= ctrl_d;
      end
   end

   // -----------------------------------------------------------------
   // debug mode sequencing and halt line
   // -----------------------------------------------------------------
   always_comb begin
      dbg_d   = dbg_q;
      hold_d  = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
      go_d    = 1'b0;
      ex_d    = 1'b0;
      cause_d = cause_q;
      ran_d   = ran_q;
      case (dbg_q)
         ECC_D_RUN: begin
            if (unl_s && !hl_s && (hold_q == 3'h0)) begin
               dbg_d = ECC_D_HALT;
            end
         end
         ECC_D_HALT: begin
            if (core_halted_in) begin
               dbg_d   = ECC_D_DBG;
               cause_d = debug_cause_in;
            end
         end
         ECC_D_DBG: begin
            if (go_req_q) begin
               go_d    = 1'b1;
               ex_d    = go_ex_q;
               cause_d = 3'h0;
               hold_d  = HOLDOFF_CYCLES;
               ran_d   = 1'b0;
               dbg_d   = go_ex_q ? ECC_D_RUN : ECC_D_STEP;
            end
         end
         ECC_D_STEP: begin
            if (!core_halted_in) begin
               ran_d = 1'b1;
            end else if (ran_q) begin
               dbg_d = ECC_D_DBG;
            end
         end
         default: dbg_d = ECC_D_RUN;
      endcase
      req_d = (dbg_d == ECC_D_HALT) || (dbg_d == ECC_D_DBG);
      oe_d  = (dbg_d == ECC_D_DBG);
   end

   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         dbg_q   <= ECC_D_RUN;
         req_q   <= 1'b0;
         oe_q    <= 1'b0;
         go_q    <= 1'b0;
         ex_q    <= 1'b0;
         cause_q <= STATUS_RESET[4:2];
         hold_q  <= 3'h0;
         ran_q   <= 1'b0;
         hlo_q   <= 1'b0;
      end else if (clk_en_in) begin
         dbg_q   <= dbg_d;
         req_q   <= req_d;
         oe_q    <= oe_d;
         go_q    <= go_d;
         ex_q    <= ex_d;
         cause_q <= cause_d;
         hold_q  <= hold_d;
         ran_q   <= ran_d;
         hlo_q   <= 1'b0;                                       // open drain: only pulls low
      end
   end

   // outputs, all from flops
   assign halt_line_out     = hlo_q;
   assign halt_line_oe_out  = oe_q;
   assign tdo_out           = tdo_q;
   assign debug_req_out     = req_q;
   assign core_go_out       = go_q;
   assign core_exit_out     = ex_q;
   assign trace_enable_out  = ctrl_q[ST_TRACE_EN_BIT];
   assign irq_mode_out      = ctrl_q[ST_IRQ_MODE_BIT];
   assign trace_advance_out = trc_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n);

   halt_entry_a:
      assert property (clk_en_in && dbg_q == ECC_D_RUN && unl_s && !hl_s && hold_q == 3'h0
                       |=> debug_req_out)
      else $error("halt request not raised after halt line low");
   ack_drive_a:
      assert property (clk_en_in && dbg_q == ECC_D_HALT && core_halted_in
                       |=> halt_line_oe_out && !halt_line_out)
      else $error("no acknowledge on entering debug");
   cmd_latch_a:
      assert property (clk_en_in && unl_s && link_q == ECC_L_CMD && upd_evt
                       |=> cmd_q == $past(sh_q[DATA_W-1:CMD_LSB]))
      else $error("command not latched on update");
   exit_with_go_a:
      assert property (core_exit_out |-> core_go_out)
      else $error("exit without go");
   go_only_debug_a:
      assert property ($rose(core_go_out) |-> $past(dbg_q) == ECC_D_DBG ##1 !core_go_out)
      else $error("go outside debug or longer than one cycle");
   read_path_a:
      assert property (clk_en_in && unl_s && link_q == ECC_L_LOAD
                       |=> link_q == ECC_L_DATA && sh_q == $past(rd_val))
      else $error("read data not loaded");
   lock_a:
      assert property (clk_en_in && !unl_s |=> link_q == ECC_L_CMD && !rf.we)
      else $error("link active while locked");
   tdo_shift_a:
      assert property (clk_en_in && tck_fall |=> tdo_out == $past(sh_q[0]))
      else $error("tdo not taken from shift register");
   core_state_a:
      assert property (halt_line_oe_out |-> stat_val[7:6] == CORE_DEBUG && stat_val[5] == 1'b0)
      else $error("core state field wrong in debug");
   no_write_run_a:
      assert property (rf.we |-> halted && !cmd_q[CMD_DIR_BIT])
      else $error("register strobe while not halted");

   cover_read_c:  cover property (link_q == ECC_L_LOAD ##1 link_q == ECC_L_DATA);
   cover_step_c:  cover property (core_go_out && !core_exit_out ##[1:200] halt_line_oe_out);
   cover_exit_c:  cover property (core_go_out && core_exit_out);
   cover_write_c: cover property (rf.we);

endmodule : ecc_controller

//--- test/ecc_jtag_host.sv
`timescale 1ns/1ps
// ---------------------------------------------
// jtag controller model on the far side of the link
// ---------------------------------------------
module ecc_jtag_host (
   input  wire logic clock_in,
   input  wire logic tdo_in,
   output logic      tck_out,
   output logic      tdi_out,
   output logic      shift_out,
   output logic      update_out
);
   // tck stands low outside frames, tdi rests high
   initial begin
      tck_out = 1'b0;
      tdi_out = 1'b1;
      shift_out = 1'b0;
      update_out = 1'b0;
   end
   // half of a 160 ns tck period
   task automatic half();
      repeat (4) @(posedge clock_in);
   endtask : half
   // n bits lsb first, then update
   task automatic frame(input int n, input logic [23:0] din, output logic [23:0] dout);
      dout = 24'h0;
      tck_out <= 1'b1;
      half();
      tck_out <= 1'b0;
      half();
      shift_out <= 1'b1;
      for (int i = 0; i < n; i++) begin
         tdi_out <= din[i];
         half();
         tck_out <= 1'b1;
         half();
         dout[i] = tdo_in;
         tck_out <= 1'b0;
      end
      tdi_out <= 1'b1;
      shift_out <= 1'b0;
      half();
      update_out <= 1'b1;
      half();
      update_out <= 1'b0;
      half();
   endtask : frame
endmodule : ecc_jtag_host

//--- test/emulation_command_controller_tb.sv
`timescale 1ns/1ps
module emulation_command_controller_tb import ecc_pkg::*;;
   logic clk = 0, rstn = 0, unl = 0, pull = 0, halted = 0, cwait = 0, got_v = 0, back = 0, bwait = 0;
   logic [2:0] cause, busy = 0;
   logic [23:0] gdb, hin, got;
   logic [15:0] fa, da, ea, tr;
   logic tck, tdi, shd, upd, tdo, oe, dreq, go, ex, te, im, adv, hlo;
   int error_cnt = 0, compares = 0, go_n = 0, ex_n = 0, adv_n = 0, seed = 41;
   logic [23:0] exp_q[$];
   logic [4:0] wsel[6] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h0D, 5'h0A};
   logic [7:0] rsel[8] = '{8'h89, 8'h8B, 8'h8F, 8'h90, 8'h91, 8'h92, 8'h83, 8'h8E};
   always #10 clk = ~clk;
   // ---------------------------------------------
   // design, link partner, core stand-in
   // ---------------------------------------------
   ecc_controller i_dut (.clock_in(clk), .resetn_in(rstn), .clk_en_in(1'b1), .tck_in(tck), .tdi_in(tdi),
      .shift_dr_in(shd), .update_dr_in(upd), .unlock_in(unl), .halt_line_in(~(oe | pull)),
      .halt_line_out(hlo), .halt_line_oe_out(oe), .tdo_out(tdo), .core_halted_in(halted), .core_wait_in(cwait),
      .core_bus_wait_in(bwait), .debug_cause_in(cause), .gdb_capture_in(gdb), .held_instr_in(hin),
      .fetch_addr_in(fa), .decode_addr_in(da), .exec_addr_in(ea), .trace_data_in(tr),
      .debug_req_out(dreq), .core_go_out(go), .core_exit_out(ex), .trace_enable_out(te),
      .irq_mode_out(im), .trace_advance_out(adv));
   ecc_jtag_host i_host (.clock_in(clk), .tdo_in(tdo), .tck_out(tck), .tdi_out(tdi), .shift_out(shd),
      .update_out(upd));
   // core halts on request, drops halt for a go, rehalts after a step
   always @(posedge clk) begin
      if (go === 1'b1) begin
         busy <= 3'h3;
         back <= ~ex;
         go_n++;
      end else if (busy != 3'h0) busy <= busy - 3'h1;
      halted <= (go !== 1'b1) && (busy == 3'h0) && (dreq | back);
      if (ex === 1'b1) ex_n++;
      if (adv === 1'b1) adv_n++;
   end
   task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // read results against oldest note
   always @(posedge clk) if (got_v) check("rdata", exp_q.pop_front(), got);
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic wait_oe(input logic lvl);
      int k;
      for (k = 0; k < 300 && oe !== lvl; k++) @(posedge clk);
      if (oe !== lvl) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask : wait_oe
   // command frame, then data frame unless no register; reads note e
   task automatic acc(input logic [7:0] c, input logic [23:0] din, input logic [23:0] e);
      logic [23:0] d;
      int n;
      n = (c[4:0] inside {SEL_STATUS, SEL_GDB, SEL_PDB, SEL_HELD, SEL_GOTO}) ? 24 : 16;
      i_host.frame(8, {16'h0, c}, d);
      if (c[4:0] != SEL_NONE) begin
         i_host.frame(n, din, d);
         if (c[7]) begin
            exp_q.push_back(e);
            got <= d;
            got_v <= 1'b1;
            @(posedge clk);
            got_v <= 1'b0;
         end
      end
   endtask : acc
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      logic [23:0] v;
      {gdb, hin} = {$random(seed), $random(seed)};
      {fa, da, ea, tr} = {$random(seed), $random(seed)};
      cause = 3'($random(seed));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      check("oe", 24'h0, 24'(oe));
      acc(8'h00, 24'h000003, 24'h0);
      acc(8'h80, 24'h0, 24'h0);
      $display("locked done");
      unl <= 1'b1;
      cwait <= 1'b1;
      acc(8'h00, 24'hFFFFFD, 24'h0);
      acc(8'h80, 24'h0, 24'h000041);
      check("te_im", 24'h2, {22'h0, te, im});
      cwait <= 1'b0;
      bwait <= 1'b1;
      acc(8'h80, 24'h0, 24'h000081);
      bwait <= 1'b0;
      pull <= 1'b1;
      wait_oe(1'b1);
      check("hl_out", 24'h0, 24'(hlo));
      pull <= 1'b0;
      check("dreq", 24'h1, 24'(dreq));
      acc(8'h80, 24'h0, {16'h0, 3'b110, cause, 2'b01});
      $display("halt done");
      foreach (wsel[i]) begin
         v = $random(seed);
         if (i < 5) v[23:16] = 8'h0;
         acc({3'b011, wsel[i]} & ((i < 5) ? 8'hFF : 8'h1F), v, 24'h0);
         acc({3'b100, wsel[i]}, 24'h0, v);
      end
      acc(8'h09, ~gdb, 24'h0);
      foreach (rsel[i]) acc(rsel[i], 24'h0, (i == 0) ? gdb : (i == 1) ? hin :
         {8'h0, (i == 2) ? fa : (i == 3) ? da : (i == 4) ? ea : (i == 5) ? tr : 16'h0});
      check("adv", 24'h1, 24'(adv_n));
      check("go_none", 24'h0, 24'(go_n));
      $display("registers done");
      acc(8'h4A, 24'h0, 24'h0);
      wait_oe(1'b1);
      check("step", 24'h1, 24'(go_n + ex_n));
      acc(8'h7F, 24'h0, 24'h0);
      wait_oe(1'b0);
      check("exit", 24'h2, 24'(go_n + ex_n - 1));
      check("dreq", 24'h0, 24'(dreq));
      $display("go done");
      tally_and_finish();
   end
endmodule : emulation_command_controller_tb
